// >>> verilog/dpw_pkg.sv
// What this block does
// - Address changes only while strobe or chip select are inactive high.
// - With output enable low, write pulse covers turn-off plus data setup; the block holds output enable high in writes and uses WP_CYC.
// - Array: chip select low, flag select high; flags: the reverse.
// - Host holds write for the hold time after stall deasserts.
// - In slave mode stall input asserted no later than write start.
package dpw_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int ADDR_W = 14;
	localparam int DATA_W = 16;
	localparam int FLAG_ADDR_W = 3;

	// Figures in ns
	localparam int WRITE_PULSE_NS = 20;
	localparam int WRITE_HIGHZ_NS = 15;
	localparam int DATA_SETUP_NS = 15;
	localparam int WRITE_HOLD_AFTER_STALL_NS = 20;
	localparam int STALL_INPUT_BEFORE_WRITE_NS = 0;
	localparam int STALL_ASSERT_MAX_NS = 25;
	localparam int PORT_DELAY_NS = 55;
	localparam int SEM_WRITE_TO_READ_NS = 5;
	localparam int READ_ACCESS_NS = 35;

	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int WP_CYC = ns_to_cyc(WRITE_PULSE_NS);
	localparam int WP_OE_CYC = ns_to_cyc(WRITE_HIGHZ_NS + DATA_SETUP_NS);
	localparam int WH_CYC = ns_to_cyc(WRITE_HOLD_AFTER_STALL_NS);
	localparam int WB_CYC = ns_to_cyc(STALL_INPUT_BEFORE_WRITE_NS);
	localparam int BAA_CYC = ns_to_cyc(STALL_ASSERT_MAX_NS);
	localparam int PDLY_CYC = ns_to_cyc(PORT_DELAY_NS);
	localparam int SWR_CYC = ns_to_cyc(SEM_WRITE_TO_READ_NS);
	localparam int RD_CYC = ns_to_cyc(READ_ACCESS_NS);
	localparam int CNT_W = 4;

	// User request
	typedef struct packed {
		logic              write;
		logic              flag_space;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} dpw_req_t;

	// Port pins driven by the host
	typedef struct packed {
		logic              chip_sel_n;
		logic              flag_space_select_n;
		logic              rw_n;
		logic              out_en_n;
		logic              high_byte_sel_n;
		logic              low_byte_sel_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dout;
		logic [DATA_W-1:0] dout_en_n;
	} dpw_pins_t;

	localparam dpw_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
		{ADDR_W{1'b0}}, {DATA_W{1'b0}}, {DATA_W{1'b1}}};
endpackage

// >>> verilog/dpw_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dpw_sync
(
	// Clock
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              ce,
	// Data
	input  wire logic [dpw_pkg::DATA_W:0] d,
	output logic      [dpw_pkg::DATA_W:0] q
);
	import dpw_pkg::*;
	logic [DATA_W:0] s1_q;

	// Two stages; first stage feeds only the second
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s1_q <= '1;
			q    <= '1;
		end
		else if (ce)
		begin
			s1_q <= d;
			q    <= s1_q;
		end
	end
endmodule
`default_nettype wire

// >>> verilog/dpw_host.sv
`timescale 1ns/1ps
`default_nettype none
module dpw_host
(
	// Clock
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic                    ce,
	// User side
	input  wire logic                    req_valid,
	input  wire dpw_pkg::dpw_req_t       req,
	output logic                         req_ready,
	output logic                         rsp_valid,
	output logic [dpw_pkg::DATA_W-1:0]   rsp_data,
	output logic                         rsp_stalled,
	// Device port pins
	output dpw_pkg::dpw_pins_t           pins,
	input  wire logic [dpw_pkg::DATA_W-1:0] din,
	input  wire logic                    stall_n_in
);
	import dpw_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_READ, ST_RECOVER} dpw_state_t;
	dpw_state_t state_q;
	dpw_req_t   cur_q;
	logic [CNT_W-1:0] cnt_q;
	logic       saw_stall_q;
	logic [DATA_W:0] sync_q;
	logic       stall_s;

	dpw_sync u_sync
	(
		.clk (clk),
		.rst (rst),
		.ce  (ce),
		.d   ({stall_n_in, din}),
		.q   (sync_q)
	);
	assign stall_s = ~sync_q[DATA_W];

	// Sequencer: address set while strobes high, then strobe
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_q     <= ST_IDLE;
			cur_q       <= '0;
			cnt_q       <= '0;
			saw_stall_q <= 1'b0;
			pins        <= PINS_IDLE;
			req_ready   <= 1'b1;
			rsp_valid   <= 1'b0;
			rsp_data    <= '0;
			rsp_stalled <= 1'b0;
		end
		else if (ce)
		begin
			rsp_valid <= 1'b0;
			case (state_q)
				ST_IDLE:
				begin
					if (req_valid)
					begin
						cur_q     <= req;
						req_ready <= 1'b0;
						// Address only moves while every strobe is high
						pins.addr <= req.flag_space ?
							{{(ADDR_W-FLAG_ADDR_W){1'b0}}, req.addr[FLAG_ADDR_W-1:0]} : req.addr;
						// Chip select and flag select before strobe so outputs stay off
						pins.chip_sel_n          <= req.flag_space;
						pins.flag_space_select_n <= ~req.flag_space;
						// Byte selects high in flag space so whole word returns flag
						pins.high_byte_sel_n <= req.flag_space;
						pins.low_byte_sel_n  <= req.flag_space;
						pins.dout     <= req.flag_space ? {{(DATA_W-1){1'b0}}, req.wdata[0]} : req.wdata;
						cnt_q       <= CNT_W'(WB_CYC);
						saw_stall_q <= 1'b0;
						state_q     <= ST_SETUP;
					end
				end
				ST_SETUP:
				begin
					// Select settles a cycle ahead of the strobe
					if (cnt_q > CNT_W'(1))
						cnt_q <= cnt_q - CNT_W'(1);
					else if (cur_q.write)
					begin
						pins.rw_n      <= 1'b0;
						pins.out_en_n  <= 1'b1;
						pins.dout_en_n <= '0;
						cnt_q   <= CNT_W'(WP_CYC);
						state_q <= ST_STROBE;
					end
					else
					begin
						pins.out_en_n <= 1'b0;
						cnt_q   <= CNT_W'(cur_q.flag_space ? SWR_CYC + RD_CYC : PDLY_CYC + RD_CYC);
						state_q <= ST_READ;
					end
				end
				ST_STROBE:
				begin
					// A stalled write is held, then kept for the hold time
					if (stall_s && !cur_q.flag_space)
					begin
						saw_stall_q <= 1'b1;
						cnt_q       <= CNT_W'(WH_CYC);
					end
					else if (cnt_q > CNT_W'(1))
						cnt_q <= cnt_q - CNT_W'(1);
					else
					begin
						pins.rw_n      <= 1'b1;
						pins.dout_en_n <= '1;
						state_q        <= ST_RECOVER;
					end
				end
				ST_READ:
				begin
					if (stall_s && !cur_q.flag_space)
					begin
						saw_stall_q <= 1'b1;
						cnt_q       <= CNT_W'(PDLY_CYC);
					end
					else if (cnt_q > CNT_W'(1))
						cnt_q <= cnt_q - CNT_W'(1);
					else
					begin
						rsp_data <= cur_q.flag_space ? {DATA_W{sync_q[0]}} : sync_q[DATA_W-1:0];
						pins.out_en_n <= 1'b1;
						state_q <= ST_RECOVER;
					end
				end
				ST_RECOVER:
				begin
					// Selects rise after strobe; next address only then
					pins.chip_sel_n          <= 1'b1;
					pins.flag_space_select_n <= 1'b1;
					pins.high_byte_sel_n     <= 1'b1;
					pins.low_byte_sel_n      <= 1'b1;
					rsp_valid   <= 1'b1;
					rsp_stalled <= saw_stall_q;
					req_ready   <= 1'b1;
					state_q     <= ST_IDLE;
				end
				default:
				begin
					state_q <= ST_IDLE;
					pins    <= PINS_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> testbench/dpw_props.sv
`timescale 1ns/1ps
`default_nettype none
module dpw_props
(
	// Watched ports
	input wire logic               clk,
	input wire logic               rst,
	input wire logic               req_valid,
	input wire logic               req_ready,
	input wire logic               rsp_valid,
	input wire logic               stall_n_in,
	input wire dpw_pkg::dpw_pins_t pins
);
	import dpw_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Strobe, select and data lines
	sel_excl_a: assert property (pins.chip_sel_n || pins.flag_space_select_n)
		else $error("both selects low");
	write_sel_a: assert property (!pins.rw_n |-> !(pins.chip_sel_n && pins.flag_space_select_n))
		else $error("write with no select");
	addr_change_a: assert property (!$stable(pins.addr) |-> pins.rw_n)
		else $error("address moved during write");
	write_pulse_a: assert property ($fell(pins.rw_n) |-> !pins.rw_n [*2])
		else $error("write pulse too short");
	write_data_a: assert property (!pins.rw_n |-> pins.out_en_n && pins.dout_en_n == '0)
		else $error("data not driven in write");
	sel_stable_a: assert property (!pins.rw_n |-> $stable(pins.chip_sel_n) && $stable(pins.flag_space_select_n))
		else $error("select moved in write");
	// Hold after stall, stall needs slack for the synchroniser
	stall_hold_a: assert property ($rose(stall_n_in) && !pins.rw_n |-> !pins.rw_n [*3])
		else $error("write released early");
	resp_bound_a: assert property (req_valid && req_ready |-> ##[3:60] rsp_valid)
		else $error("no response");
endmodule
`default_nettype wire

// >>> testbench/dpw_dev.sv
`timescale 1ns/1ps
`default_nettype none
module dpw_dev
(
	// Port pins
	input wire logic                       clk,
	input wire dpw_pkg::dpw_pins_t         pins,
	// Opposite port
	input wire logic                       other_en,
	input wire logic [dpw_pkg::ADDR_W-1:0] other_addr,
	output logic [dpw_pkg::DATA_W-1:0]     din,
	output logic                           stall_n
);
	import dpw_pkg::*;
	logic [DATA_W-1:0] mem [2**ADDR_W];
	logic [7:0]        flag_q = 8'hff;
	// This port always loses the arbitration, the harsher case
	// Stall comes straight from the match, no setup window applied
	assign stall_n = !(other_en && !pins.chip_sel_n && other_addr == pins.addr);
	// Store at the end of the strobe, dropped while stalled
	always @(posedge pins.rw_n)
		if (!pins.chip_sel_n && stall_n) mem[pins.addr] = pins.dout;
		else if (!pins.flag_space_select_n) flag_q[pins.addr[2:0]] = pins.dout[0];
	// Released bus toggles so stale data never matches
	assign din = pins.out_en_n ? {8{clk, ~clk}} : !pins.chip_sel_n ? mem[pins.addr]
		: {DATA_W{flag_q[pins.addr[2:0]]}};
endmodule
`default_nettype wire

// >>> testbench/dpw_test.sv
`timescale 1ns/1ps
`default_nettype none
module dpw_test;
	import dpw_pkg::*;
	logic clk = 0, rst = 1, req_valid = 0, req_ready, rsp_valid, rsp_stalled, stall_n, other_en = 0, s, b;
	logic [ADDR_W-1:0] other_addr = '0, a;
	logic [DATA_W-1:0] rsp_data, din, d, q;
	dpw_req_t          req = '0;
	dpw_pins_t         pins;
	int                num_errors = 0, check_count = 0, i;
	always #5 clk = ~clk;
	dpw_host u_dut (.clk(clk), .rst(rst), .ce(1'b1), .req_valid(req_valid), .req(req), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_stalled(rsp_stalled), .pins(pins), .din(din),
		.stall_n_in(stall_n));
	dpw_dev u_dev (.clk(clk), .pins(pins), .other_en(other_en), .other_addr(other_addr), .din(din),
		.stall_n(stall_n));
	task automatic check(input logic [DATA_W:0] got, exp);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One request, wait for its response under a bound
	task automatic access(input logic w, f, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] wd);
		req = '{w, f, ad, wd};
		req_valid = 1;
		@(posedge clk);
		#1 req_valid = 0;
		for (int n = 0; n < 100 && rsp_valid !== 1'b1; n++)
		begin
			@(posedge clk);
			#1;
		end
		check(rsp_valid, 1'b1);
		q = rsp_data;
		s = rsp_stalled;
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Runs take about 500 cycles
	initial
	begin
		#100us num_errors++;
		complete_run();
	end
	initial
	begin
		void'($urandom(32'h68a3));
		repeat (12) @(posedge clk);
		#1 rst = 0;
		// Array words, corner addresses first
		for (i = 0; i < 20; i++)
		begin
			a = i == 0 ? '0 : i == 1 ? '1 : ADDR_W'($urandom);
			d = DATA_W'($urandom);
			access(1, 0, a, d);
			access(0, 0, a, '0);
			check({s, q}, {1'b0, d});
		end
		// Every flag, upper address and data bits random
		for (i = 0; i < 8; i++)
		begin
			b = 1'($urandom);
			d = DATA_W'($urandom);
			d[0] = b;
			a = ADDR_W'($urandom);
			a[2:0] = i[2:0];
			access(1, 1, a, d);
			access(0, 1, ADDR_W'(i), '0);
			check({s, q}, {1'b0, {DATA_W{b}}});
		end
		// Opposite port on the same address
		a = ADDR_W'($urandom);
		d = DATA_W'($urandom);
		other_addr = a;
		other_en = 1;
		access(1, 1, a, 16'h0001);
		check(s, 1'b0);
		fork
			access(1, 0, a, d);
			begin
				repeat (8) @(posedge clk);
				#1 other_en = 0;
			end
		join
		check(s, 1'b1);
		access(0, 0, a, '0);
		check(q, d);
		complete_run();
	end
endmodule
bind dpw_host dpw_props u_props (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
	.rsp_valid(rsp_valid), .stall_n_in(stall_n_in), .pins(pins));
`default_nettype wire
